// >>> logic/autoneg_np_defines.svh
/*
  Register indices, field positions and reset values of the
  auto-negotiation next-page register bank.
  Assumes a 5-bit management register index and 16-bit registers.
*/
`ifndef AUTONEG_NP_DEFINES_SVH
`define AUTONEG_NP_DEFINES_SVH

// ==========================================================
// register indices
`define ANNP_IDX_LP_BASE    5'h05
`define ANNP_IDX_EXPANSION  5'h06
`define ANNP_IDX_NP_TX      5'h07
`define ANNP_IDX_NP_RX      5'h08

// ==========================================================
// expansion register fields
`define ANNP_EXP_LOC_ABLE   6
`define ANNP_EXP_LOC_SEL    5
`define ANNP_EXP_PD_FAULT   4
`define ANNP_EXP_LP_NP_ABLE 3
`define ANNP_EXP_NP_ABLE    2
`define ANNP_EXP_PAGE_RX    1
`define ANNP_EXP_LP_AN_ABLE 0

// ==========================================================
// next-page word fields
`define ANNP_NP_NEXT        15
`define ANNP_NP_ACK         14
`define ANNP_NP_MSG         13
`define ANNP_NP_ACK2        12
`define ANNP_NP_TOGGLE      11

// ==========================================================
// reset values
`define ANNP_TX_RESET       16'h2001
`define ANNP_RX_RESET       16'h0000
`define ANNP_BASE_RESET     16'h0000

`endif

// >>> logic/autoneg_np_pkg.sv
/*
  Types shared by the next-page register bank.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package autoneg_np_pkg;

  // ==========================================================
  // management register access request
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } mgmt_req_t;

  // ==========================================================
  // next-page word layout
  typedef struct packed {
    logic        next_page;
    logic        ack;
    logic        msg_page;
    logic        ack2;
    logic        toggle;
    logic [10:0] code;
  } np_word_t;

endpackage

// >>> logic/latch_high_flag.sv
/*
  Sticky flag set by a hardware event, cleared by a read.
  Assumes set and clear are single-cycle pulses on the same clock.
*/
`timescale 1ns/1ps

module latch_high_flag (
  // clock and reset
  input  wire logic ref_clk_in,
  input  wire logic reset_in,
  // control
  input  wire logic set_in,
  input  wire logic clear_in,
  // state
  output logic      flag_out
);

  // ==========================================================
  // set wins over a clear in the same cycle
  wire next_flag = set_in | (flag_out & ~clear_in);

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      flag_out <= 1'b0;
    end else begin
      flag_out <= next_flag;
    end
  end

endmodule

// >>> logic/autoneg_next_page_regs.sv
/*
  Auto-negotiation next-page register bank: expansion, transmit
  next page, receive next page and partner base page registers.
  Assumes a management frame decoder that presents one register
  access per request pulse, and an arbitration engine that reports
  received pages, sent next pages and parallel detection faults.
*/
//
// Function
// (RULE1) expansion bit 6 always reads one
// (RULE2) bit 5 reads one; next pages go to 8
// (RULE3) parallel detection fault latched, cleared by read
// (RULE4) bit 3 shows partner next page ability
// (RULE5) bit 2 always reads one
// (RULE6) page received latched, cleared by read
// (RULE7) bit 0 shows partner negotiation ability
// (RULE8) transmit next page flag writable, resets zero
// (RULE9) transmit message page bit writable, resets one
// (RULE10) transmit second acknowledge writable, resets zero
// (RULE11) transmit toggle read-only, resets zero
// (RULE12) transmit code field writable, resets one
// (RULE13) receive next page flag read-only
// (RULE14) receive acknowledge bit read-only
// (RULE15) receive message, ack2, code read-only
// (RULE16) receive toggle read-only
// (RULE17) partner base page held at index 5
// (RULE18) toggle flips per sent page; load on receipt (the bank only flips it on np_sent_in and never loads it)
// (RULE19) reserved bits read zero, ignore writes
`timescale 1ns/1ps
`include "autoneg_np_defines.svh"

module autoneg_next_page_regs (
  // clock and reset
  input  wire logic                     ref_clk_in,
  input  wire logic                     reset_in,
  // management register access
  input  wire autoneg_np_pkg::mgmt_req_t mgmt_req_in,
  output logic [15:0]                   mgmt_rdata_out,
  output logic                          mgmt_rvalid_out,
  // arbitration engine events
  input  wire logic                     lp_page_valid_in,
  input  wire logic                     lp_page_base_in,
  input  wire logic [15:0]              lp_page_in,
  input  wire logic                     lp_an_able_in,
  input  wire logic                     pd_fault_in,
  input  wire logic                     np_sent_in,
  // outgoing next page
  output autoneg_np_pkg::np_word_t      tx_page_out
);

  // ==========================================================
  // storage
  autoneg_np_pkg::np_word_t tx_page;
  autoneg_np_pkg::np_word_t rx_page;
  logic [15:0]              lp_base;
  logic                     lp_an_able;
  logic                     pd_fault;
  logic                     page_rx;

  // ==========================================================
  // access decode
  wire rd_exp   = mgmt_req_in.rd & (mgmt_req_in.addr == `ANNP_IDX_EXPANSION);
  wire wr_tx    = mgmt_req_in.wr & (mgmt_req_in.addr == `ANNP_IDX_NP_TX);
  wire load_rx  = lp_page_valid_in & ~lp_page_base_in;
  wire load_bse = lp_page_valid_in & lp_page_base_in;

  // ==========================================================
  // latched event flags
  latch_high_flag u_pd_fault (
    .ref_clk_in (ref_clk_in),
    .reset_in   (reset_in),
    .set_in     (pd_fault_in),  // RULE3
    .clear_in   (rd_exp),       // RULE3
    .flag_out   (pd_fault)
  );

  latch_high_flag u_page_rx (
    .ref_clk_in (ref_clk_in),
    .reset_in   (reset_in),
    .set_in     (lp_page_valid_in), // RULE6
    .clear_in   (rd_exp),           // RULE6
    .flag_out   (page_rx)
  );

  // ==========================================================
  // expansion register image
  logic [15:0] exp_word;
  always_comb begin
    exp_word                          = 16'h0000;       // RULE19
    exp_word[`ANNP_EXP_LOC_ABLE]      = 1'b1;           // RULE1
    exp_word[`ANNP_EXP_LOC_SEL]       = 1'b1;           // RULE2
    exp_word[`ANNP_EXP_PD_FAULT]      = pd_fault;       // RULE3
    exp_word[`ANNP_EXP_LP_NP_ABLE]    = lp_base[`ANNP_NP_NEXT]; // RULE4
    exp_word[`ANNP_EXP_NP_ABLE]       = 1'b1;           // RULE5
    exp_word[`ANNP_EXP_PAGE_RX]       = page_rx;        // RULE6
    exp_word[`ANNP_EXP_LP_AN_ABLE]    = lp_an_able;     // RULE7
  end

  // ==========================================================
  // transmit next page: writable fields, toggle kept by hardware
  autoneg_np_pkg::np_word_t next_tx_page;
  always_comb begin
    next_tx_page = tx_page;
    if (wr_tx) begin
      next_tx_page.next_page = mgmt_req_in.wdata[`ANNP_NP_NEXT];  // RULE8
      next_tx_page.msg_page  = mgmt_req_in.wdata[`ANNP_NP_MSG];   // RULE9
      next_tx_page.ack2      = mgmt_req_in.wdata[`ANNP_NP_ACK2];  // RULE10
      next_tx_page.code      = mgmt_req_in.wdata[10:0];           // RULE12
    end
    next_tx_page.ack = 1'b0; // RULE19
    if (np_sent_in) begin
      next_tx_page.toggle = ~tx_page.toggle; // RULE18
    end
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      tx_page <= autoneg_np_pkg::np_word_t'(`ANNP_TX_RESET); // RULE11
    end else begin
      tx_page <= next_tx_page;
    end
  end

  // ==========================================================
  // pages from the link partner
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rx_page <= autoneg_np_pkg::np_word_t'(`ANNP_RX_RESET);
    end else if (load_rx) begin
      rx_page <= autoneg_np_pkg::np_word_t'(lp_page_in); // RULE2 RULE13 RULE14 RULE15 RULE16
    end
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      lp_base <= `ANNP_BASE_RESET;
    end else if (load_bse) begin
      lp_base <= lp_page_in; // RULE17
    end
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      lp_an_able <= 1'b0;
    end else begin
      lp_an_able <= lp_an_able_in; // RULE7
    end
  end

  // ==========================================================
  // read path; writes to read-only registers are ignored
  logic [15:0] rd_sel;
  always_comb begin
    case (mgmt_req_in.addr)
      `ANNP_IDX_LP_BASE:   rd_sel = lp_base;
      `ANNP_IDX_EXPANSION: rd_sel = exp_word;
      `ANNP_IDX_NP_TX:     rd_sel = tx_page;
      `ANNP_IDX_NP_RX:     rd_sel = rx_page;
      default:             rd_sel = 16'h0000;
    endcase
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      mgmt_rdata_out  <= 16'h0000;
      mgmt_rvalid_out <= 1'b0;
    end else begin
      mgmt_rdata_out  <= mgmt_req_in.rd ? rd_sel : 16'h0000;
      mgmt_rvalid_out <= mgmt_req_in.rd;
    end
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      tx_page_out <= autoneg_np_pkg::np_word_t'(`ANNP_TX_RESET);
    end else begin
      tx_page_out <= next_tx_page;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (reset_in);

  sequence s_read_exp;
    mgmt_req_in.rd && mgmt_req_in.addr == `ANNP_IDX_EXPANSION;
  endsequence

  sequence s_read_rx;
    mgmt_req_in.rd && mgmt_req_in.addr == `ANNP_IDX_NP_RX;
  endsequence

  sequence s_write_tx;
    mgmt_req_in.wr && mgmt_req_in.addr == `ANNP_IDX_NP_TX;
  endsequence

  sequence s_next_page_in;
    lp_page_valid_in && !lp_page_base_in;
  endsequence

  sequence s_read_tx;
    mgmt_req_in.rd && mgmt_req_in.addr == `ANNP_IDX_NP_TX;
  endsequence

  sequence s_read_base;
    mgmt_req_in.rd && mgmt_req_in.addr == `ANNP_IDX_LP_BASE;
  endsequence

  sequence s_base_page_in;
    lp_page_valid_in && lp_page_base_in;
  endsequence

  sequence s_fault_then_read;
    pd_fault_in ##1 s_read_exp;
  endsequence

  sequence s_page_then_read;
    lp_page_valid_in ##1 s_read_exp;
  endsequence

  a_exp_const_bits: assert property ( // RULE1
    s_read_exp |=> mgmt_rvalid_out && mgmt_rdata_out[15:5] == 11'h003
      && mgmt_rdata_out[2])
    else $error("expansion constant bits wrong");

  a_exp_lp_np: assert property ( // RULE4
    s_read_exp |=> mgmt_rdata_out[3] == $past(lp_base[15]))
    else $error("partner next page ability not shown");

  a_pdf_latch: assert property ( // RULE3
    pd_fault_in |=> pd_fault)
    else $error("fault flag not latched");

  a_pdf_clear: assert property ( // RULE3
    rd_exp && !pd_fault_in |=> !pd_fault)
    else $error("fault flag not cleared by read");

  a_page_rx_flag: assert property ( // RULE6
    s_page_then_read |=> mgmt_rdata_out[1] && (!page_rx || $past(lp_page_valid_in)))
    else $error("page received flag wrong");

  a_tx_toggle: assert property ( // RULE18
    np_sent_in |=> tx_page.toggle != $past(tx_page.toggle))
    else $error("toggle did not invert");

  a_tx_write: assert property ( // RULE12
    s_write_tx |=> tx_page.code == $past(mgmt_req_in.wdata[10:0])
      && tx_page.next_page == $past(mgmt_req_in.wdata[15])
      && !tx_page.ack)
    else $error("transmit page write lost");

  a_tx_toggle_ro: assert property ( // RULE11
    (s_write_tx and !np_sent_in) |=> $stable(tx_page.toggle))
    else $error("toggle changed by write");

  a_rx_load: assert property ( // RULE15
    s_next_page_in ##1 s_read_rx |=> mgmt_rdata_out == $past(lp_page_in, 2))
    else $error("received next page not readable");

  a_base_hold: assert property ( // RULE17
    s_next_page_in |=> $stable(lp_base))
    else $error("next page overwrote base page");

  a_pdf_read: assert property ( // RULE3
    s_fault_then_read |=> mgmt_rdata_out[`ANNP_EXP_PD_FAULT])
    else $error("fault flag not readable");

  a_pdf_hold: assert property ( // RULE3
    pd_fault && !rd_exp |=> pd_fault)
    else $error("fault flag dropped without read");

  a_page_rx_set: assert property ( // RULE6
    lp_page_valid_in |=> page_rx)
    else $error("page received flag not set");

  a_page_rx_hold: assert property ( // RULE6
    page_rx && !rd_exp |=> page_rx)
    else $error("page received flag dropped without read");

  a_page_rx_clear: assert property ( // RULE6
    rd_exp && !lp_page_valid_in |=> !page_rx)
    else $error("page received flag not cleared by read");

  a_exp_an_able: assert property ( // RULE7
    s_read_exp |=> mgmt_rdata_out[`ANNP_EXP_LP_AN_ABLE] == $past(lp_an_able_in, 2))
    else $error("partner negotiation ability not shown");

  a_exp_reserved: assert property ( // RULE19
    s_read_exp |=> mgmt_rdata_out[15:7] == 9'h000)
    else $error("expansion reserved bits not zero");

  a_tx_msg_page: assert property ( // RULE9
    s_write_tx |=> tx_page.msg_page == $past(mgmt_req_in.wdata[`ANNP_NP_MSG]))
    else $error("message page bit write lost");

  a_tx_ack2: assert property ( // RULE10
    s_write_tx |=> tx_page.ack2 == $past(mgmt_req_in.wdata[`ANNP_NP_ACK2]))
    else $error("second acknowledge write lost");

  a_tx_toggle_hold: assert property ( // RULE11
    !np_sent_in |=> $stable(tx_page.toggle))
    else $error("toggle changed without a sent page");

  a_tx_read: assert property ( // RULE8
    s_read_tx |=> mgmt_rdata_out == $past(tx_page_out))
    else $error("transmit page read differs from output");

  a_tx_ack_read: assert property ( // RULE19
    s_read_tx |=> !mgmt_rdata_out[`ANNP_NP_ACK])
    else $error("transmit reserved bit not zero");

  a_tx_out_toggle: assert property ( // RULE18
    np_sent_in |=> tx_page_out.toggle != $past(tx_page_out.toggle))
    else $error("outgoing toggle did not invert");

  a_tx_code_hold: assert property ( // RULE12
    !wr_tx |=> $stable(tx_page.code))
    else $error("code field changed without write");

  a_rx_hold: assert property ( // RULE15
    !load_rx |=> $stable(rx_page))
    else $error("received next page changed without page");

  a_rx_read: assert property ( // RULE13
    s_read_rx |=> mgmt_rdata_out == $past(rx_page))
    else $error("received next page read wrong");

  a_base_load: assert property ( // RULE17
    s_base_page_in |=> lp_base == $past(lp_page_in))
    else $error("base page not stored");

  a_base_read: assert property ( // RULE17
    s_read_base |=> mgmt_rdata_out == $past(lp_base))
    else $error("base page read wrong");

  a_read_idle: assert property ( // RULE19
    !mgmt_req_in.rd |=> !mgmt_rvalid_out && mgmt_rdata_out == 16'h0000)
    else $error("read outputs active without read");

  a_read_valid: assert property (
    mgmt_req_in.rd |=> mgmt_rvalid_out)
    else $error("read not answered");

  a_unmapped_zero: assert property ( // RULE19
    mgmt_req_in.rd && (mgmt_req_in.addr < `ANNP_IDX_LP_BASE
      || mgmt_req_in.addr > `ANNP_IDX_NP_RX) |=> mgmt_rdata_out == 16'h0000)
    else $error("unmapped read not zero");

endmodule

// >>> bench/link_partner_model.sv
/*
  Link partner model: presents received pages, fault and ability events.
  Assumes the bank samples its event inputs on the rising clock edge.
*/
`timescale 1ns/1ps

module link_partner_model (
  // clock
  input  wire logic        ref_clk_in,
  // events toward the bank
  output logic             lp_page_valid_out,
  output logic             lp_page_base_out,
  output logic [15:0]      lp_page_out,
  output logic             lp_an_able_out,
  output logic             pd_fault_out
);
  initial begin
    lp_page_valid_out = 1'b0;
    lp_page_base_out  = 1'b0;
    lp_page_out       = 16'h0000;
    lp_an_able_out    = 1'b0;
    pd_fault_out      = 1'b0;
  end

  // ==========================================================
  // one-cycle page; word line scrambled once released
  task automatic send_page(input logic base, input logic [15:0] word);
    @(posedge ref_clk_in);
    #1;
    lp_page_valid_out = 1'b1;
    lp_page_base_out  = base;
    lp_page_out       = word;
    @(posedge ref_clk_in);
    #1;
    lp_page_valid_out = 1'b0;
    lp_page_base_out  = ~base;
    lp_page_out       = ~word;
  endtask

  task automatic fault_pulse();
    @(posedge ref_clk_in);
    #1;
    pd_fault_out = 1'b1;
    @(posedge ref_clk_in);
    #1;
    pd_fault_out = 1'b0;
  endtask

  task automatic set_an_able(input logic able);
    @(posedge ref_clk_in);
    #1;
    lp_an_able_out = able;
  endtask
endmodule

// >>> bench/tb.sv
/*
  Self-checking bench of the next-page register bank.
  Assumes the link partner model and the design files are compiled first.
*/
`timescale 1ns/1ps

module tb;
  logic                      ref_clk_in = 1'b0;
  logic                      reset_in = 1'b1;
  logic                      np_sent = 1'b0;
  autoneg_np_pkg::mgmt_req_t req = '0;
  autoneg_np_pkg::np_word_t  tx_page;
  logic [15:0]               rdata;
  logic                      rvalid;
  logic                      pg_valid;
  logic                      pg_base;
  logic [15:0]               pg_word;
  logic                      an_able;
  logic                      fault;
  int                        mismatches = 0;
  int                        samples_checked = 0;

  always #5 ref_clk_in = ~ref_clk_in;

  autoneg_next_page_regs autoneg_next_page_regs_inst (
    .ref_clk_in(ref_clk_in), .reset_in(reset_in), .mgmt_req_in(req),
    .mgmt_rdata_out(rdata), .mgmt_rvalid_out(rvalid),
    .lp_page_valid_in(pg_valid), .lp_page_base_in(pg_base), .lp_page_in(pg_word),
    .lp_an_able_in(an_able), .pd_fault_in(fault), .np_sent_in(np_sent),
    .tx_page_out(tx_page));

  link_partner_model link_partner_model_inst (
    .ref_clk_in(ref_clk_in), .lp_page_valid_out(pg_valid), .lp_page_base_out(pg_base),
    .lp_page_out(pg_word), .lp_an_able_out(an_able), .pd_fault_out(fault));

  // ==========================================================
  // compare, access tasks and closing
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [4:0] addr, input logic [15:0] data);
    @(posedge ref_clk_in);
    #1;
    req = {1'b0, 1'b1, addr, data};
    @(posedge ref_clk_in);
    #1;
    req.wr = 1'b0;
  endtask

  task automatic rd(input string name, input logic [4:0] addr, input logic [15:0] exp);
    @(posedge ref_clk_in);
    #1;
    req = {1'b1, 1'b0, addr, 16'h0000};
    @(posedge ref_clk_in);
    #1;
    req.rd = 1'b0;
    chk({name, "_valid"}, 16'h0001, {15'h0000, rvalid});
    chk(name, exp, rdata);
  endtask

  task automatic sent_pulse();
    @(posedge ref_clk_in);
    #1;
    np_sent = 1'b1;
    @(posedge ref_clk_in);
    #1;
    np_sent = 1'b0;
  endtask

  task automatic end_sim();
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    #100000;
    mismatches++;
    end_sim();
  end

  // ==========================================================
  // test sequence
  initial begin
    repeat (2) @(posedge ref_clk_in);
    #1;
    reset_in = 1'b0;
    chk("tx_reset", 16'h2001, tx_page);
    rd("exp_reset", 5'h06, 16'h0064);
    rd("tx_reset_rd", 5'h07, 16'h2001);
    rd("rx_reset", 5'h08, 16'h0000);
    rd("base_reset", 5'h05, 16'h0000);
    wr(5'h07, 16'hFFFF);
    rd("tx_ones", 5'h07, 16'hB7FF);
    chk("tx_out_ones", 16'hB7FF, tx_page);
    wr(5'h07, 16'h0000);
    rd("tx_zero", 5'h07, 16'h0000);
    wr(5'h06, 16'hFFFF);
    rd("exp_ro", 5'h06, 16'h0064);
    wr(5'h08, 16'hFFFF);
    rd("rx_ro", 5'h08, 16'h0000);
    rd("unmapped", 5'h1F, 16'h0000);
    sent_pulse();
    rd("toggle_one", 5'h07, 16'h0800);
    chk("tx_out_toggle", 16'h0800, tx_page);
    sent_pulse();
    rd("toggle_zero", 5'h07, 16'h0000);
    link_partner_model_inst.fault_pulse();
    rd("fault_set", 5'h06, 16'h0074);
    rd("fault_clr", 5'h06, 16'h0064);
    link_partner_model_inst.set_an_able(1'b1);
    repeat (2) @(posedge ref_clk_in);
    rd("an_able", 5'h06, 16'h0065);
    link_partner_model_inst.send_page(1'b0, 16'hDABC);
    rd("rx_page", 5'h08, 16'hDABC);
    rd("page_set", 5'h06, 16'h0067);
    rd("page_clr", 5'h06, 16'h0065);
    link_partner_model_inst.send_page(1'b1, 16'h8001);
    rd("base_page", 5'h05, 16'h8001);
    rd("rx_kept", 5'h08, 16'hDABC);
    rd("lp_np_able", 5'h06, 16'h006F);
    link_partner_model_inst.send_page(1'b0, 16'h2555);
    rd("rx_page2", 5'h08, 16'h2555);
    fork
      link_partner_model_inst.fault_pulse();
      rd("fault_race", 5'h06, 16'h006F);
    join
    rd("fault_won", 5'h06, 16'h007D);
    end_sim();
  end
endmodule
